// ==== nand_host_ctrl.sv ====
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module nand_host_ctrl
   import nand_host_pkg::*;
#(
   parameter int RB_TIMEOUT_CYC = 100000
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Software register port
   input wire sw_req_s swReq,
   output logic [31:0] swRdata,
   // Flash pins
   output nand_pins_s pins,
   input wire logic [7:0] ioIn,
   input wire logic rbIn
);

   phase_e phase_q, phaseNext;
   op_e op_q, newOp;
   cyc_e cyc_q;
   act_e act;
   logic [7:0] tmr_q, waitLen, txByte, memRd, areaCmd;
   logic [7:0] ioS1_q, ioS2_q, devStatus_q;
   logic rbS1_q, rbS2_q, tmo_q, cfgErr_q, wpEn_q;
   logic [9:0] col_q, len_q, left_q, bufPtr_q, bufPtr_d;
   logic [9:0] seqIdx_q, seqIdx_d, rdAddr, wrAddr;
   logic [15:0] row_q;
   logic [19:0] rbTmr_q;
   logic busy, cycDone, capture, ctrlWr, startOp, abortReset, lenBad;
   logic bufAcc, memWe;
   logic [7:0] memWd;

   assign busy = (phase_q != PH_IDLE);
   assign newOp = op_e'(swReq.wdata[2:0]);
   assign ctrlWr = swReq.wr && (swReq.addr == REG_CTRL);
   // Never let a transfer run past column 527: that would trigger the
   // automatic next-page load in the middle of our burst.
   assign lenBad = (len_q == 10'h000) ||
      (({1'b0, col_q} + {1'b0, len_q}) > {1'b0, PAGE_BYTES});
   assign startOp = ctrlWr && !busy && (newOp != OP_NONE) &&
      (newOp <= OP_RESET) &&
      !(((newOp == OP_READ) || (newOp == OP_PROG)) && lenBad);
   // Reset is the only order taken while the device is busy
   assign abortReset = ctrlWr && busy && (newOp == OP_RESET) &&
      (phase_q == PH_RB);
   assign cycDone = ((cyc_q == CYC_WHIGH) || (cyc_q == CYC_RHIGH) ||
      (cyc_q == CYC_WAIT)) && (tmr_q == 8'h00);
   assign capture = (cyc_q == CYC_RLOW) && (tmr_q == 8'h00);

   // Pointer command chosen from the start column
   always_comb begin
      if (col_q < COL_B_BASE) begin
         areaCmd = CMD_PTR_A;
      end else if (col_q < COL_C_BASE) begin
         areaCmd = CMD_PTR_B;
      end else begin
         areaCmd = CMD_PTR_C;
      end
   end

   always_comb begin
      act = ACT_NONE;
      txByte = 8'h00;
      waitLen = 8'h01;
      case (phase_q)
         PH_PTR: begin
            act = ACT_CMD;
            txByte = areaCmd;
         end
         PH_CMD: begin
            act = ACT_CMD;
            txByte = (op_q == OP_RESET) ? CMD_RESET : CMD_LOAD;
         end
         PH_A0: begin
            act = ACT_ADR;
            txByte = col_q[7:0];
         end
         PH_A1: begin
            act = ACT_ADR;
            txByte = row_q[7:0];
         end
         PH_A2: begin
            act = ACT_ADR;
            txByte = row_q[15:8];
         end
         PH_DIN: begin
            act = ACT_DAT;
            txByte = memRd;
         end
         PH_CONF: begin
            act = ACT_CMD;
            txByte = CMD_CONFIRM;
         end
         PH_STCMD: begin
            act = ACT_CMD;
            txByte = CMD_STATUS;
         end
         PH_WB: begin
            act = ACT_WAIT;
            waitLen = WB_CYC;
         end
         PH_GAP: begin
            act = ACT_WAIT;
            waitLen = WHR_CYC;
         end
         PH_DONE: begin
            act = ACT_WAIT;
            waitLen = CEH_CYC;
         end
         PH_DOUT, PH_STRD: begin
            act = ACT_READ;
         end
         default: begin
            act = ACT_NONE;
         end
      endcase
   end

   always_comb begin
      case (phase_q)
         PH_PTR: phaseNext = (op_q == OP_PROG) ? PH_CMD : PH_A0;
         PH_CMD: phaseNext = (op_q == OP_RESET) ? PH_WB : PH_A0;
         PH_A0: phaseNext = PH_A1;
         PH_A1: phaseNext = PH_A2;
         PH_A2: phaseNext = (op_q == OP_PROG) ? PH_DIN : PH_WB;
         PH_DIN: phaseNext = (left_q == 10'h001) ? PH_CONF : PH_DIN;
         PH_CONF: phaseNext = PH_WB;
         PH_WB: phaseNext = PH_RB;
         PH_RB: begin
            if (op_q == OP_READ) begin
               phaseNext = PH_GAP;
            end else if (op_q == OP_PROG) begin
               phaseNext = PH_STCMD;
            end else begin
               phaseNext = PH_DONE;
            end
         end
         PH_STCMD: phaseNext = PH_GAP;
         PH_GAP: phaseNext = (op_q == OP_READ) ? PH_DOUT : PH_STRD;
         PH_DOUT: phaseNext = (left_q == 10'h001) ? PH_DONE : PH_DOUT;
         PH_STRD: phaseNext = PH_DONE;
         default: phaseNext = PH_IDLE;
      endcase
   end

   // Input synchronisers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ioS1_q <= 8'h00;
         ioS2_q <= 8'h00;
         rbS1_q <= 1'b0;
         rbS2_q <= 1'b0;
      end else begin
         ioS1_q <= ioIn;
         ioS2_q <= ioS1_q;
         rbS1_q <= rbIn;
         rbS2_q <= rbS1_q;
      end
   end

   // Strobe timing engine
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cyc_q <= CYC_IDLE;
         tmr_q <= 8'h00;
      end else begin
         case (cyc_q)
            CYC_IDLE: begin
               if ((act == ACT_CMD) || (act == ACT_ADR) ||
                   (act == ACT_DAT)) begin
                  cyc_q <= CYC_WSET;
                  tmr_q <= W_SET_CYC - 8'h01;
               end else if (act == ACT_READ) begin
                  cyc_q <= CYC_RLOW;
                  tmr_q <= R_LOW_CYC - 8'h01;
               end else if (act == ACT_WAIT) begin
                  cyc_q <= CYC_WAIT;
                  tmr_q <= waitLen - 8'h01;
               end
            end
            CYC_WSET: begin
               if (tmr_q == 8'h00) begin
                  cyc_q <= CYC_WLOW;
                  tmr_q <= W_LOW_CYC - 8'h01;
               end else begin
                  tmr_q <= tmr_q - 8'h01;
               end
            end
            CYC_WLOW: begin
               if (tmr_q == 8'h00) begin
                  cyc_q <= CYC_WHIGH;
                  tmr_q <= W_HIGH_CYC - 8'h01;
               end else begin
                  tmr_q <= tmr_q - 8'h01;
               end
            end
            CYC_RLOW: begin
               if (tmr_q == 8'h00) begin
                  cyc_q <= CYC_RHIGH;
                  tmr_q <= R_HIGH_CYC - 8'h01;
               end else begin
                  tmr_q <= tmr_q - 8'h01;
               end
            end
            CYC_WHIGH, CYC_RHIGH, CYC_WAIT: begin
               if (tmr_q == 8'h00) begin
                  cyc_q <= CYC_IDLE;
               end else begin
                  tmr_q <= tmr_q - 8'h01;
               end
            end
            default: begin
               cyc_q <= CYC_IDLE;
            end
         endcase
      end
   end

   // Pins lag the engine by one cycle; every pin is a flip-flop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pins <= '{cle: 1'b0, ale: 1'b0, ceN: 1'b1, weN: 1'b1,
                   readStrobeN: 1'b1, wpN: 1'b0, ioOeN: 1'b1,
                   ioOut: 8'h00};
      end else begin
         // Held low for a whole operation until PH_DONE; pauses are never needed
         pins.ceN <= (phase_q == PH_IDLE) || (phase_q == PH_DONE);
         pins.wpN <= wpEn_q;
         pins.weN <= (cyc_q != CYC_WLOW);
         pins.readStrobeN <= (cyc_q != CYC_RLOW);
         pins.ioOeN <= !((cyc_q == CYC_WSET) || (cyc_q == CYC_WLOW) ||
            (cyc_q == CYC_WHIGH));
         pins.cle <= (cyc_q != CYC_IDLE) && (act == ACT_CMD);
         pins.ale <= (cyc_q != CYC_IDLE) && (act == ACT_ADR);
         if (cyc_q == CYC_WSET) begin
            pins.ioOut <= txByte;
         end
      end
   end

   // Operation sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_q <= PH_IDLE;
         op_q <= OP_NONE;
         left_q <= 10'h000;
         rbTmr_q <= 20'h00000;
      end else if (startOp) begin
         op_q <= newOp;
         left_q <= len_q;
         rbTmr_q <= 20'h00000;
         if ((newOp == OP_READ) || (newOp == OP_PROG)) begin
            phase_q <= PH_PTR;
         end else if (newOp == OP_STATUS) begin
            phase_q <= PH_STCMD;
         end else begin
            phase_q <= PH_CMD;
         end
      end else if (abortReset) begin
         op_q <= OP_RESET;
         phase_q <= PH_CMD;
         rbTmr_q <= 20'h00000;
      end else if (phase_q == PH_RB) begin
         // Open-drain line read through the pull-up
         if (rbS2_q) begin
            phase_q <= phaseNext;
            rbTmr_q <= 20'h00000;
         end else if (rbTmr_q == 20'(RB_TIMEOUT_CYC - 1)) begin
            phase_q <= PH_DONE;
            rbTmr_q <= 20'h00000;
         end else begin
            rbTmr_q <= rbTmr_q + 20'h00001;
         end
      end else if (cycDone) begin
         phase_q <= phaseNext;
         if ((phase_q == PH_DIN) || (phase_q == PH_DOUT)) begin
            left_q <= left_q - 10'h001;
         end
      end
   end

   // Result flags and captured status byte
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tmo_q <= 1'b0;
         cfgErr_q <= 1'b0;
         devStatus_q <= 8'h00;
      end else begin
         if ((phase_q == PH_RB) && !rbS2_q && !abortReset &&
             (rbTmr_q == 20'(RB_TIMEOUT_CYC - 1))) begin
            tmo_q <= 1'b1;
         end else if (startOp) begin
            tmo_q <= 1'b0;
         end
         if (ctrlWr && !busy && lenBad &&
             ((newOp == OP_READ) || (newOp == OP_PROG))) begin
            cfgErr_q <= 1'b1;
         end else if (startOp) begin
            cfgErr_q <= 1'b0;
         end
         if (capture && (phase_q == PH_STRD)) begin
            devStatus_q <= ioS2_q;
         end
      end
   end

   always_comb begin
      seqIdx_d = seqIdx_q;
      if (startOp) begin
         seqIdx_d = 10'h000;
      end else if (cycDone &&
                   ((phase_q == PH_DIN) || (phase_q == PH_DOUT))) begin
         seqIdx_d = seqIdx_q + 10'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seqIdx_q <= 10'h000;
      end else begin
         seqIdx_q <= seqIdx_d;
      end
   end

   // Buffer pointer for software access while idle
   assign bufAcc = !busy && (swReq.addr == REG_BUFDATA) &&
      (swReq.wr || swReq.rd);

   always_comb begin
      bufPtr_d = bufPtr_q;
      if (!busy && swReq.wr && (swReq.addr == REG_BUFPTR)) begin
         bufPtr_d = (swReq.wdata[9:0] < PAGE_BYTES) ?
            swReq.wdata[9:0] : 10'h000;
      end else if (bufAcc) begin
         bufPtr_d = (bufPtr_q == PAGE_BYTES - 10'h001) ?
            10'h000 : bufPtr_q + 10'h001;
      end
   end

   assign rdAddr = busy ? seqIdx_d : bufPtr_d;
   assign memWe = busy ? (capture && (phase_q == PH_DOUT)) :
      (swReq.wr && (swReq.addr == REG_BUFDATA));
   assign wrAddr = busy ? seqIdx_q : bufPtr_q;
   assign memWd = busy ? ioS2_q : swReq.wdata[7:0];

   nand_page_buf u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(memWe),
      .wrAddr(wrAddr),
      .wrData(memWd),
      .rdAddr(rdAddr),
      .rdData(memRd)
   );

   // Configuration registers; refused while an operation runs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         col_q <= COL_RST;
         row_q <= ROW_RST;
         len_q <= LEN_RST;
         wpEn_q <= WPEN_RST;
         bufPtr_q <= 10'h000;
      end else begin
         bufPtr_q <= bufPtr_d;
         if (swReq.wr && !busy) begin
            case (swReq.addr)
               REG_COL: col_q <= swReq.wdata[9:0];
               REG_ROW: row_q <= swReq.wdata[15:0];
               REG_LEN: len_q <= swReq.wdata[9:0];
               REG_WPCFG: wpEn_q <= swReq.wdata[0];
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         swRdata <= 32'h00000000;
      end else if (swReq.rd) begin
         case (swReq.addr)
            REG_CTRL: swRdata <= {29'h0, op_q};
            REG_COL: swRdata <= {22'h0, col_q};
            REG_ROW: swRdata <= {16'h0, row_q};
            REG_LEN: swRdata <= {22'h0, len_q};
            REG_STAT: swRdata <= {16'h0, devStatus_q, 4'h0, cfgErr_q,
                                  tmo_q, rbS2_q, busy};
            REG_BUFPTR: swRdata <= {22'h0, bufPtr_q};
            REG_BUFDATA: swRdata <= busy ? 32'h0 : {24'h0, memRd};
            REG_WPCFG: swRdata <= {31'h0, wpEn_q};
            default: swRdata <= 32'h00000000;
         endcase
      end else begin
         swRdata <= 32'h00000000;
      end
   end

endmodule

// ==== nand_host_pkg.sv ====
package nand_host_pkg;

   // Clock and timing
   localparam int CLK_MHZ = 100;
   localparam int W_SET_NS = 10;
   localparam int W_LOW_NS = 30;
   localparam int W_HIGH_NS = 20;
   // Read strobe low long enough to cover access time plus sync delay
   localparam int R_LOW_NS = 70;
   localparam int R_HIGH_NS = 20;
   localparam int WB_NS = 100;
   localparam int WHR_NS = 60;
   localparam int CEH_NS = 100;
   localparam int PAGE_LOAD_TIME_US = 10;
   localparam logic [7:0] W_SET_CYC = 8'((W_SET_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] W_LOW_CYC = 8'((W_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] W_HIGH_CYC = 8'((W_HIGH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] R_LOW_CYC = 8'((R_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] R_HIGH_CYC = 8'((R_HIGH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] WB_CYC = 8'((WB_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] WHR_CYC = 8'((WHR_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] CEH_CYC = 8'((CEH_NS * CLK_MHZ + 999) / 1000);
   localparam int PAGE_LOAD_CYC = PAGE_LOAD_TIME_US * CLK_MHZ;

   // Device commands
   localparam logic [7:0] CMD_PTR_A = 8'h00;
   localparam logic [7:0] CMD_PTR_B = 8'h01;
   localparam logic [7:0] CMD_PTR_C = 8'h50;
   localparam logic [7:0] CMD_LOAD = 8'h80;
   localparam logic [7:0] CMD_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_RESET = 8'hFF;

   // Page geometry
   localparam logic [9:0] COL_B_BASE = 10'h100;
   localparam logic [9:0] COL_C_BASE = 10'h200;
   localparam logic [9:0] PAGE_BYTES = 10'h210;

   // Controller registers
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_COL = 8'h04;
   localparam logic [7:0] REG_ROW = 8'h08;
   localparam logic [7:0] REG_LEN = 8'h0C;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_BUFPTR = 8'h14;
   localparam logic [7:0] REG_BUFDATA = 8'h18;
   localparam logic [7:0] REG_WPCFG = 8'h1C;
   localparam logic [9:0] COL_RST = 10'h000;
   localparam logic [15:0] ROW_RST = 16'h0000;
   localparam logic [9:0] LEN_RST = 10'h001;
   localparam logic WPEN_RST = 1'b0;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_READ = 3'b001,
      OP_PROG = 3'b010,
      OP_STATUS = 3'b011,
      OP_RESET = 3'b100
   } op_e;

   typedef enum logic [3:0] {
      PH_IDLE = 4'b0000,
      PH_PTR = 4'b0001,
      PH_CMD = 4'b0010,
      PH_A0 = 4'b0011,
      PH_A1 = 4'b0100,
      PH_A2 = 4'b0101,
      PH_DIN = 4'b0110,
      PH_CONF = 4'b0111,
      PH_WB = 4'b1000,
      PH_RB = 4'b1001,
      PH_STCMD = 4'b1010,
      PH_GAP = 4'b1011,
      PH_DOUT = 4'b1100,
      PH_STRD = 4'b1101,
      PH_DONE = 4'b1110
   } phase_e;

   typedef enum logic [2:0] {
      CYC_IDLE = 3'b000,
      CYC_WSET = 3'b001,
      CYC_WLOW = 3'b010,
      CYC_WHIGH = 3'b011,
      CYC_RLOW = 3'b100,
      CYC_RHIGH = 3'b101,
      CYC_WAIT = 3'b110
   } cyc_e;

   typedef enum logic [2:0] {
      ACT_NONE = 3'b000,
      ACT_CMD = 3'b001,
      ACT_ADR = 3'b010,
      ACT_DAT = 3'b011,
      ACT_READ = 3'b100,
      ACT_WAIT = 3'b101
   } act_e;

   typedef struct packed {
      logic cle;
      logic ale;
      logic ceN;
      logic weN;
      logic readStrobeN;
      logic wpN;
      logic ioOeN;
      logic [7:0] ioOut;
   } nand_pins_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } sw_req_s;

endpackage

// ==== nand_page_buf.sv ====
`timescale 1ns/100ps
module nand_page_buf
   import nand_host_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write side
   input wire logic wrEn,
   input wire logic [9:0] wrAddr,
   input wire logic [7:0] wrData,
   // Read side
   input wire logic [9:0] rdAddr,
   output logic [7:0] rdData
);

   logic [7:0] mem [0:PAGE_BYTES-1];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData <= 8'h00;
      end else begin
         rdData <= mem[rdAddr];
      end
   end

endmodule

// ==== nand_host_ctrl_props.sv ====
`timescale 1ns/100ps
module nand_host_ctrl_props
   import nand_host_pkg::*;
#(
   parameter int RB_TIMEOUT_CYC = 100000
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Software side
   input wire sw_req_s swReq,
   input wire logic [31:0] swRdata,
   // Flash side
   input wire nand_pins_s pins,
   input wire logic [7:0] ioIn,
   input wire logic rbIn
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   we_select_a: assert property (!pins.weN |-> !pins.ceN && !pins.ioOeN)
      else $error("write strobe without select or bus drive");
   re_select_a: assert property (!pins.readStrobeN |-> !pins.ceN && pins.ioOeN)
      else $error("read strobe while bus driven or deselected");
   latch_sel_a: assert property (pins.cle || pins.ale |-> !pins.ceN && !(pins.cle && pins.ale))
      else $error("bad latch enable combination");
   we_pulse_a: assert property ($fell(pins.weN) |-> !pins.weN [*3] ##1 pins.weN)
      else $error("write strobe width wrong");
   re_pulse_a: assert property ($fell(pins.readStrobeN) |-> !pins.readStrobeN [*7] ##1 pins.readStrobeN)
      else $error("read strobe width wrong");
   wdata_hold_a: assert property (!pins.weN && !$past(pins.weN) |-> $stable(pins.ioOut))
      else $error("bus byte moved under write strobe");
   latch_hold_a: assert property ($rose(pins.weN) |-> $stable(pins.cle) && $stable(pins.ale))
      else $error("latch enable moved at strobe rise");
   ce_gap_a: assert property ($rose(pins.ceN) |-> pins.ceN [*8])
      else $error("chip enable high too briefly");

   cover property ($fell(pins.weN) && pins.cle && pins.ioOut == CMD_LOAD);
   cover property ($fell(pins.readStrobeN));
   cover property ($fell(rbIn));
endmodule

bind nand_host_ctrl nand_host_ctrl_props #(.RB_TIMEOUT_CYC(RB_TIMEOUT_CYC)) props (
   .clk(clk), .rst_n(rst_n), .swReq(swReq), .swRdata(swRdata),
   .pins(pins), .ioIn(ioIn), .rbIn(rbIn));

// ==== nand_dev_model.sv ====
`timescale 1ns/100ps
module nand_dev_model
   import nand_host_pkg::*;
#(
   parameter int BUSY_NS = 300
)
(
   // Host strobes and bus level
   input wire nand_pins_s pins,
   input wire logic [7:0] ioBus,
   // Device drive, low enables
   output logic [7:0] devOut,
   output logic devOeN,
   output logic rbOeN
);
   logic [7:0] mem[int];
   logic [7:0] pageReg[528];
   logic [1:0] area = 2'd0;
   logic [1:0] adrCnt = 2'd0;
   logic [9:0] col = 10'h000;
   logic [15:0] row = 16'h0000;
   logic statMode = 1'b0;
   logic progMode = 1'b0;
   logic loaded = 1'b0;
   logic failBit = 1'b0;
   initial devOut = 8'h00;
   initial devOeN = 1'b1;
   initial rbOeN = 1'b1;

   // Open-drain pull low for the busy time
   task automatic goBusy();
      rbOeN = 1'b0;
      #(BUSY_NS);
      rbOeN = 1'b1;
   endtask

   task automatic loadPage();
      for (int k = 0; k < 528; k++)
         pageReg[k] = mem.exists({row, 10'(k)}) ? mem[{row, 10'(k)}] : 8'hFF;
   endtask

   task automatic doCmd(input logic [7:0] c);
      logic [7:0] old;
      if (!rbOeN && c != CMD_STATUS && c != CMD_RESET)
         return;
      statMode = (c == CMD_STATUS);
      if (c == CMD_PTR_A || c == CMD_PTR_B || c == CMD_PTR_C) begin
         area = (c == CMD_PTR_A) ? 2'd0 : (c == CMD_PTR_B) ? 2'd1 : 2'd2;
         progMode = 1'b0;
         adrCnt = 2'd0;
      end
      if (c == CMD_LOAD) begin
         progMode = 1'b1;
         loaded = 1'b0;
         adrCnt = 2'd0;
         foreach (pageReg[k]) pageReg[k] = 8'hFF;
      end
      // Unloaded bytes stay FF so they never alter cells
      if (c == CMD_CONFIRM && progMode && loaded) begin
         failBit = 1'b0;
         for (int k = 0; k < 528; k++) begin
            old = mem.exists({row, 10'(k)}) ? mem[{row, 10'(k)}] : 8'hFF;
            mem[{row, 10'(k)}] = old & pageReg[k];
            failBit |= |(~pageReg[k] & mem[{row, 10'(k)}]);
         end
         progMode = 1'b0;
         area = (area == 2'd1) ? 2'd0 : area;
         fork goBusy(); join_none
      end
      if (c == CMD_RESET) begin
         area = 2'd0;
         progMode = 1'b0;
         failBit = 1'b0;
         fork goBusy(); join_none
      end
   endtask

   task automatic doAdr(input logic [7:0] a);
      case (adrCnt)
         2'd0: col = (area == 2'd2) ? COL_C_BASE + 10'(a[3:0]) : {area[0], a};
         2'd1: row[7:0] = a;
         default: row[15:8] = a;
      endcase
      if (adrCnt == 2'd2 && !progMode) begin
         loadPage();
         area = (area == 2'd1) ? 2'd0 : area;
         fork goBusy(); join_none
      end
      adrCnt = adrCnt + 2'd1;
   endtask

   // Page register survives chip enable going high
   always @(posedge pins.weN) begin
      if (!pins.ceN && pins.cle)
         doCmd(ioBus);
      else if (!pins.ceN && pins.ale)
         doAdr(ioBus);
      else if (!pins.ceN && progMode && rbOeN) begin
         pageReg[col] = ioBus;
         col = col + 10'h001;
         loaded = 1'b1;
      end
   end

   always @(negedge pins.readStrobeN) begin
      if (!pins.ceN && statMode) begin
         devOut = {pins.wpN, rbOeN, 5'b00000, failBit};
         devOeN = 1'b0;
      end else if (!pins.ceN) begin
         devOut = pageReg[col];
         devOeN = 1'b0;
         col = col + 10'h001;
         if (col == PAGE_BYTES) begin
            col = (area == 2'd2) ? COL_C_BASE : 10'h000;
            row = row + 16'h0001;
            loadPage();
            fork goBusy(); join_none
         end
      end
   end

   always @(posedge pins.readStrobeN or posedge pins.ceN) devOeN = 1'b1;
endmodule

// ==== nand_host_ctrl_tb.sv ====
`timescale 1ns/100ps
module nand_host_ctrl_tb;
   import nand_host_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   sw_req_s swReq = '0;
   logic [31:0] swRdata;
   nand_pins_s pins;
   logic [7:0] devOut;
   logic [7:0] ioIn;
   logic [7:0] lastIo = 8'h00;
   logic devOeN;
   logic rbOeN;
   logic rdSeen = 1'b0;
   logic [63:0] expQ[$];
   logic [63:0] note;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] got;
   logic [7:0] dat[4];
   logic [9:0] cols[3];
   logic [15:0] row;

   always #5 clk = ~clk;
   // Undriven bus shows the inverse of its last level
   assign ioIn = !pins.ioOeN ? pins.ioOut : (!devOeN ? devOut : ~lastIo);
   always @(posedge clk) if (!pins.ioOeN || !devOeN) lastIo <= ioIn;

   // Ready/busy wire has a pull-up
   nand_host_ctrl #(.RB_TIMEOUT_CYC(200)) dut (.clk(clk), .rst_n(rst_n),
      .swReq(swReq), .swRdata(swRdata), .pins(pins), .ioIn(ioIn),
      .rbIn(rbOeN));
   nand_dev_model #(.BUSY_NS(300)) flash (.pins(pins), .ioBus(ioIn),
      .devOut(devOut), .devOeN(devOeN), .rbOeN(rbOeN));

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      swReq.addr <= a;
      swReq.wdata <= d;
      swReq.wr <= 1'b1;
      @(posedge clk);
      swReq.wr <= 1'b0;
   endtask

   // A zero mask only drains the note without comparing
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      @(posedge clk);
      swReq.addr <= a;
      swReq.rd <= 1'b1;
      expQ.push_back({e & m, m});
      @(posedge clk);
      swReq.rd <= 1'b0;
      @(negedge clk);
      got = swRdata;
   endtask

   task automatic op(input logic [2:0] code);
      wr(REG_CTRL, {29'h0, code});
      got = 32'h1;
      for (int i = 0; i < 400 && got[0] !== 1'b0; i++)
         rd(REG_STAT, 32'h0, 32'h0);
   endtask

   always @(posedge clk) rdSeen <= swReq.rd;
   always @(negedge clk) begin
      if (rdSeen) begin
         note = expQ.pop_front();
         if (note[31:0] != 32'h0) begin
            comparisons++;
            if ((swRdata & note[31:0]) !== note[63:32]) begin
               bad_count++;
               $display("Error at %0t: read %h want %h", $time, swRdata, note[63:32]);
            end
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         $display("Error at %0t: run did not finish", $time);
         finish_test();
      end
   end

   initial begin
      row = 16'($urandom(32'h2433D203));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(REG_LEN, 32'(LEN_RST), 32'h3FF);
      rd(REG_WPCFG, 32'h0, 32'h1);
      rd(8'h40, 32'h0, 32'hFFFFFFFF);
      op(3'd3);
      rd(REG_STAT, 32'h4002, 32'hFF0F);
      wr(REG_WPCFG, 32'h1);
      op(3'd4);
      op(3'd3);
      rd(REG_STAT, 32'hC002, 32'hFF0F);
      cols[0] = 10'($urandom_range(252));
      cols[1] = COL_B_BASE + 10'($urandom_range(252));
      cols[2] = COL_C_BASE + 10'($urandom_range(12));
      foreach (cols[j]) begin
         row = 16'($urandom());
         wr(REG_BUFPTR, 32'h0);
         foreach (dat[i]) begin
            dat[i] = 8'($urandom());
            wr(REG_BUFDATA, {24'h0, dat[i]});
         end
         wr(REG_COL, {22'h0, cols[j]});
         wr(REG_ROW, {16'h0, row});
         rd(REG_ROW, {16'h0, row}, 32'hFFFF);
         wr(REG_LEN, 32'h4);
         op(3'd2);
         rd(REG_STAT, 32'hC002, 32'hFF0F);
         op(3'd1);
         wr(REG_BUFPTR, 32'h0);
         foreach (dat[i]) rd(REG_BUFDATA, {24'h0, dat[i]}, 32'hFF);
         wr(REG_ROW, {16'h0, row ^ 16'h0001});
         op(3'd1);
         wr(REG_BUFPTR, 32'h0);
         rd(REG_BUFDATA, 32'hFF, 32'hFF);
      end
      wr(REG_LEN, 32'h0);
      wr(REG_CTRL, 32'h1);
      rd(REG_STAT, 32'h8, 32'h9);
      wr(REG_COL, {22'h0, COL_C_BASE});
      wr(REG_LEN, 32'd17);
      wr(REG_CTRL, 32'h2);
      rd(REG_STAT, 32'h8, 32'h9);
      finish_test();
   end
endmodule
